// ---- hw/rcr_regs.sv ----
// Receiver command-word register bank with serial command port.
`timescale 1ns/1ps
module rcr_regs #(
    parameter logic [7:0] THR_BASE = 8'h00_10,
    parameter logic [7:0] THR_STEP = 8'h00_06
) (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       ser_clk,
    input  wire logic       ser_data,
    input  wire logic       ser_sel_n,
    input  wire logic [7:0] strength_level,
    input  wire logic       data_quality_detect,
    input  wire logic       clock_lock,
    input  wire logic       valid_data,
    output logic            clock_out,
    output logic [2:0]      baseband_bw_sel,
    output logic            clock_out_disable,
    output logic [3:0]      crystal_load_sel,
    output logic [1:0]      pin_function_sel,
    output logic [1:0]      amp_gain_sel,
    output logic [2:0]      strength_threshold,
    output logic            receiver_enable,
    output logic            strength_flag,
    output logic            multi_pin_out,
    output logic            status_read
);
    import rcr_pkg::*;

    logic [2:0]       pins;
    logic             sclk_s;
    logic             sdat_s;
    logic             sel_n_s;
    logic             sclk_d;
    logic             next_sclk_d;
    logic             sclk_rise;
    rcr_state_t       state;
    rcr_state_t       next_state;
    logic [15:0]      shift;
    logic [15:0]      next_shift;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic [15:0]      word;
    logic             word_done;
    logic [15:0]      cfg;
    logic [15:0]      next_cfg;
    logic [15:0]      rxc;
    logic [15:0]      next_rxc;
    logic             next_clock_out;
    logic             next_strength_flag;
    logic             next_multi_pin;
    logic             next_status_read;

    function automatic logic [7:0] gain_att(input logic [1:0] g);
        case (g)
            2'b00:   gain_att = ATT_G0;
            2'b01:   gain_att = ATT_G1;
            2'b10:   gain_att = ATT_G2;
            default: gain_att = ATT_G3;
        endcase
    endfunction

    function automatic logic [7:0] threshold(input logic [2:0] code);
        threshold = THR_BASE + 8'(THR_STEP * code);
    endfunction

    rcr_pin_sync #(
        .W           (3)
    ) u_sync (
        .clock       (clock),
        .rst_n       (rst_n),
        .pin_in      ({ser_clk, ser_data, ser_sel_n}),
        .reset_level (3'b001),
        .level       (pins)
    );

    assign sclk_s    = pins[2];
    assign sdat_s    = pins[1];
    assign sel_n_s   = pins[0];
    assign sclk_rise = sclk_s && !sclk_d;
    assign word      = {shift[14:0], sdat_s};

    // Serial framing: bits arrive MSB first on the rising serial clock.
    always_comb begin
        next_sclk_d = sclk_s;
        next_state  = state;
        next_shift  = shift;
        next_count  = count;
        word_done   = 1'b0;
        case (state)
            RCR_IDLE: begin
                next_count = '0;
                if (!sel_n_s) begin
                    next_state = RCR_SHIFT;
                end
            end
            RCR_SHIFT: begin
                if (sel_n_s) begin
                    next_state = RCR_IDLE;
                end else if (sclk_rise) begin
                    next_shift = word;
                    next_count = count + 1'b1;
                    if (count == CNT_W'(WORD_BITS - 1)) begin
                        word_done  = 1'b1;
                        next_state = RCR_WAIT;
                    end
                end
            end
            RCR_WAIT: begin
                // Extra clocks after the word are ignored until deselect.
                if (sel_n_s) begin
                    next_state = RCR_IDLE;
                end
            end
            default: begin
                next_state = RCR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sclk_d <= 1'b0;
            state  <= RCR_IDLE;
            shift  <= '0;
            count  <= '0;
        end else begin
            sclk_d <= next_sclk_d;
            state  <= next_state;
            shift  <= next_shift;
            count  <= next_count;
        end
    end

    // Register decode of a completed word.
    always_comb begin
        next_cfg         = cfg;
        next_rxc         = rxc;
        next_status_read = 1'b0;
        if (word_done) begin
            if (!word[15]) begin
                next_status_read = 1'b1;
            end else if (word[15:RX_CODE_LSB] == CMD_RX_CTRL) begin
                next_rxc = word;
            end else if (word[15:CFG_CODE_LSB] == CMD_CFG) begin
                next_cfg = word;
                if (word[CFG_BW_LSB+:3] == BW_RSVD_LO ||
                    word[CFG_BW_LSB+:3] == BW_RSVD_HI) begin
                    next_cfg[CFG_BW_LSB+:3] = cfg[CFG_BW_LSB+:3];
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cfg         <= CFG_RESET;
            rxc         <= RX_CTRL_RESET;
            status_read <= 1'b0;
        end else begin
            cfg         <= next_cfg;
            rxc         <= next_rxc;
            status_read <= next_status_read;
        end
    end

    // Field outputs. The next values feed the flops so each output
    // changes together with its register.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            baseband_bw_sel    <= CFG_RESET[CFG_BW_LSB+:3];
            clock_out_disable  <= CFG_RESET[CFG_CLKDIS];
            crystal_load_sel   <= CFG_RESET[CFG_CAP_LSB+:4];
            pin_function_sel   <= RX_CTRL_RESET[RX_PIN_LSB+:2];
            amp_gain_sel       <= RX_CTRL_RESET[RX_GAIN_LSB+:2];
            strength_threshold <= RX_CTRL_RESET[RX_THR_LSB+:3];
            receiver_enable    <= RX_CTRL_RESET[RX_EN];
        end else begin
            baseband_bw_sel    <= next_cfg[CFG_BW_LSB+:3];
            clock_out_disable  <= next_cfg[CFG_CLKDIS];
            crystal_load_sel   <= next_cfg[CFG_CAP_LSB+:4];
            pin_function_sel   <= next_rxc[RX_PIN_LSB+:2];
            amp_gain_sel       <= next_rxc[RX_GAIN_LSB+:2];
            strength_threshold <= next_rxc[RX_THR_LSB+:3];
            receiver_enable    <= next_rxc[RX_EN];
        end
    end

    // Strength detect, clock output and multipurpose pin.
    always_comb begin
        logic [7:0] att;
        logic [7:0] eff;
        att = gain_att(amp_gain_sel);
        eff = (strength_level > att) ? 8'(strength_level - att) : 8'h00_00;
        next_strength_flag = receiver_enable &&
                             (eff > threshold(strength_threshold));
        next_clock_out = clock_out_disable ? 1'b0 : !clock_out;
        case (pin_function_sel)
            PIN_STRENGTH: next_multi_pin = strength_flag;
            PIN_QUALITY:  next_multi_pin = data_quality_detect;
            PIN_LOCK:     next_multi_pin = clock_lock;
            PIN_VALID:    next_multi_pin = valid_data;
            default:      next_multi_pin = 1'b0;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            clock_out     <= 1'b0;
            strength_flag <= 1'b0;
            multi_pin_out <= 1'b0;
        end else begin
            clock_out     <= next_clock_out;
            strength_flag <= next_strength_flag;
            multi_pin_out <= next_multi_pin;
        end
    end
endmodule

// ---- hw/rcr_pkg.sv ----
// Shared constants for the receiver command-word register bank.
package rcr_pkg;
    localparam int          WORD_BITS     = 16;
    localparam int          CNT_W         = 5;
    // Command codes in the top bits of a word.
    localparam logic [7:0]  CMD_RX_CTRL   = 8'h00_C0;
    localparam logic [2:0]  CMD_CFG       = 3'b100;
    localparam int          CFG_CODE_LSB  = 13;
    localparam int          RX_CODE_LSB   = 8;
    // Reset values.
    localparam logic [15:0] CFG_RESET     = 16'h893A;
    localparam logic [15:0] RX_CTRL_RESET = 16'hC0C1;
    // Configuration word field positions.
    localparam int          CFG_CAP_LSB   = 4;
    localparam int          CFG_BW_LSB    = 1;
    localparam int          CFG_CLKDIS    = 0;
    // Receiver control word field positions.
    localparam int          RX_PIN_LSB    = 6;
    localparam int          RX_GAIN_LSB   = 4;
    localparam int          RX_THR_LSB    = 1;
    localparam int          RX_EN         = 0;
    // Reserved bandwidth codes.
    localparam logic [2:0]  BW_RSVD_LO    = 3'b000;
    localparam logic [2:0]  BW_RSVD_HI    = 3'b111;
    // Pin function codes.
    localparam logic [1:0]  PIN_STRENGTH  = 2'b00;
    localparam logic [1:0]  PIN_QUALITY   = 2'b01;
    localparam logic [1:0]  PIN_LOCK      = 2'b10;
    localparam logic [1:0]  PIN_VALID     = 2'b11;
    // Amplifier attenuation in dB per gain code.
    localparam logic [7:0]  ATT_G0        = 8'h00_00;
    localparam logic [7:0]  ATT_G1        = 8'h00_06;
    localparam logic [7:0]  ATT_G2        = 8'h00_0E;
    localparam logic [7:0]  ATT_G3        = 8'h00_14;

    typedef enum logic [1:0] {
        RCR_IDLE  = 2'b00,
        RCR_SHIFT = 2'b01,
        RCR_WAIT  = 2'b10
    } rcr_state_t;
endpackage

// ---- hw/rcr_pin_sync.sv ----
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/1ps
module rcr_pin_sync #(
    parameter int W = 1
) (
    input  wire logic         clock,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] pin_in,
    input  wire logic [W-1:0] reset_level,
    output logic      [W-1:0] level
);
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;
    logic [W-1:0] next_level;

    // A bit only moves once the last two stages agree, which hides a
    // metastable settle in the middle stage.
    always_comb begin
        for (int i = 0; i < W; i++) begin
            next_level[i] = (stage2[i] == stage3[i]) ? stage3[i] : level[i];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            // Stages start at the idle level so that an idle-high pin does
            // not look like a falling edge on the first clocks after reset.
            stage1 <= reset_level;
            stage2 <= reset_level;
            stage3 <= reset_level;
            level  <= reset_level;
        end else begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
            level  <= next_level;
        end
    end
endmodule

// ---- bench/rcr_regs_sva.sv ----
// Checker for the receiver command-word register bank.
`timescale 1ns/1ps
module rcr_regs_chk
    import rcr_pkg::*;
#(
    parameter logic [7:0] THR_BASE = 8'h00_10,
    parameter logic [7:0] THR_STEP = 8'h00_06
) (
    input wire logic       clock,
    input wire logic       rst_n,
    input wire logic       ser_sel_n,
    input wire logic [7:0] strength_level,
    input wire logic       data_quality_detect,
    input wire logic       clock_lock,
    input wire logic       valid_data,
    input wire logic       clock_out,
    input wire logic [2:0] baseband_bw_sel,
    input wire logic       clock_out_disable,
    input wire logic [3:0] crystal_load_sel,
    input wire logic [1:0] pin_function_sel,
    input wire logic [1:0] amp_gain_sel,
    input wire logic [2:0] strength_threshold,
    input wire logic       receiver_enable,
    input wire logic       strength_flag,
    input wire logic       multi_pin_out,
    input wire logic       status_read
);
    localparam int ATT [4] = '{0, 6, 14, 20};
    int   lv;
    logic exp_flag;
    logic src;
    always_comb begin
        lv       = int'(strength_level) - ATT[amp_gain_sel];
        exp_flag = receiver_enable && (lv > int'(THR_BASE)
                   + int'(THR_STEP) * int'(strength_threshold));
        src      = pin_function_sel[1] ? (pin_function_sel[0] ? valid_data
                   : clock_lock) : data_quality_detect;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Eight idle cycles on the select pin leave no word in flight.
    sequence s_idle;
        ser_sel_n [*8];
    endsequence
    chk_reset_vals: assert property (disable iff (1'b0) !rst_n |=>
        {pin_function_sel, amp_gain_sel, strength_threshold, receiver_enable}
        == 8'hC1 && !clock_out_disable && baseband_bw_sel == 3'b101)
        else $error("field not at reset value");
    chk_bw_legal: assert property (baseband_bw_sel != 3'b000
        && baseband_bw_sel != 3'b111) else $error("reserved bandwidth held");
    chk_clk_toggle: assert property (!clock_out_disable
        && $past(!clock_out_disable) && $past(rst_n) && $past(rst_n, 2)
        |-> clock_out != $past(clock_out)) else $error("clock out stuck");
    chk_clk_off: assert property (clock_out_disable
        && $past(clock_out_disable) |-> !clock_out)
        else $error("clock output active while disabled");
    chk_idle_stable: assert property (s_idle |=>
        $stable({baseband_bw_sel, clock_out_disable, crystal_load_sel,
        pin_function_sel, amp_gain_sel, strength_threshold,
        receiver_enable})) else $error("field moved");
    chk_status_one: assert property (status_read |=> !status_read)
        else $error("status strobe too long");
    chk_flag_calc: assert property ($past(rst_n) |->
        strength_flag == $past(exp_flag)) else $error("strength flag wrong");
    chk_flag_off: assert property (!receiver_enable |=> !strength_flag)
        else $error("flag with receiver off");
    chk_pin_mux: assert property ($past(rst_n)
        && $past(pin_function_sel) != 2'b00 |-> multi_pin_out == $past(src))
        else $error("pin source");
endmodule

bind rcr_regs rcr_regs_chk #(
    .THR_BASE (THR_BASE),
    .THR_STEP (THR_STEP)
) i_chk (.*);

// ---- bench/rcr_host.sv ----
// Host model that shifts command words into the serial port.
`timescale 1ns/1ps
module rcr_host (
    input  wire logic clock,
    output logic      ser_clk,
    output logic      ser_data,
    output logic      ser_sel_n
);
    initial begin
        ser_clk   = 1'b0;
        ser_data  = 1'b0;
        ser_sel_n = 1'b1;
    end
    // code bits first.
    // Short counts leave a frame incomplete, which the device must drop.
    task automatic send(input logic [15:0] w, input int nbits);
        @(negedge clock);
        ser_sel_n = 1'b0;
        for (int i = 15; i > 15 - nbits; i--) begin
            ser_data = w[i];
            repeat (5) @(negedge clock);
            ser_clk = 1'b1;
            repeat (5) @(negedge clock);
            ser_clk = 1'b0;
        end
        repeat (6) @(negedge clock);
        // A released data line floats, so it must not keep the last bit.
        ser_data  = ~ser_data;
        ser_sel_n = 1'b1;
        repeat (8) @(negedge clock);
    endtask
endmodule

// ---- bench/rcr_regs_bench.sv ----
// Self-checking bench for the receiver command-word register bank.
`timescale 1ns/1ps
module rcr_regs_bench;
    import rcr_pkg::*;
    localparam int TB = 16;
    localparam int TS = 6;
    localparam int ATT [4] = '{0, 6, 14, 20};
    logic       clock = 1'b0;
    logic       rst_n = 1'b0;
    logic       ser_clk, ser_data, ser_sel_n, clock_out, clock_out_disable;
    logic [7:0] strength_level = 8'h00;
    logic       data_quality_detect = 1'b0, clock_lock = 1'b0;
    logic       valid_data = 1'b0, receiver_enable, strength_flag;
    logic [2:0] baseband_bw_sel, strength_threshold, bw_m;
    logic [3:0] crystal_load_sel, cap_m;
    logic [1:0] pin_function_sel, amp_gain_sel;
    logic       multi_pin_out, status_read, dis_m, c;
    logic [7:0] rx_m;
    int         n_fail, n_compared, n_status;
    rcr_regs #(.THR_BASE(8'(TB)), .THR_STEP(8'(TS))) i_dut (.*);
    rcr_host i_host (.*);
    always #25 clock = ~clock;
    // Counted on the falling edge, away from the edge that launches it.
    always @(negedge clock) if (status_read === 1'b1) n_status++;
    task automatic stop_test();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic compare(input string nm, input logic [7:0] e,
                           input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic check_all();
        int lv, flag, src;
        repeat (3) @(negedge clock);
        lv   = int'(strength_level) - ATT[rx_m[5:4]];
        flag = int'(rx_m[0] && lv > TB + TS * int'(rx_m[3:1]));
        src  = rx_m[7:6] == 2'd0 ? flag :
               rx_m[7:6] == 2'd1 ? data_quality_detect :
               rx_m[7:6] == 2'd2 ? clock_lock : valid_data;
        compare("rx ctrl", rx_m, {pin_function_sel, amp_gain_sel,
                strength_threshold, receiver_enable});
        compare("bw", 8'(bw_m), 8'(baseband_bw_sel));
        compare("cap", 8'(cap_m), 8'(crystal_load_sel));
        compare("clk dis", 8'(dis_m), 8'(clock_out_disable));
        compare("flag", 8'(flag), 8'(strength_flag));
        compare("pin", 8'(src), 8'(multi_pin_out));
    endtask
    task automatic wr_rx(input logic [7:0] v);
        i_host.send({8'hC0, v}, 16);
        rx_m                = v;
        strength_level      = 8'($urandom_range(0, 80));
        data_quality_detect = 1'($urandom);
        clock_lock          = 1'($urandom);
        valid_data          = 1'($urandom);
        check_all();
    endtask
    task automatic wr_cfg(input logic [2:0] bw, input logic dis);
        logic [3:0] cap;
        cap = 4'($urandom);
        i_host.send({3'b100, 5'($urandom), cap, bw, dis}, 16);
        cap_m = cap;
        dis_m = dis;
        if (bw != 3'b000 && bw != 3'b111) bw_m = bw;
        check_all();
    endtask
    // A reset, at start or mid-run, must bring back a running clock output.
    task automatic apply_reset();
        rst_n = 1'b0;
        repeat (2) @(negedge clock);
        rst_n = 1'b1;
        rx_m  = 8'hC1;
        bw_m  = 3'b101;
        cap_m = 4'b0011;
        dis_m = 1'b0;
        check_all();
        c = clock_out;
        @(negedge clock);
        compare("clk run", 8'(!c), 8'(clock_out));
    endtask
    initial begin
        repeat (90000) @(posedge clock);
        n_fail++;
        stop_test();
    end
    initial begin
        n_fail     = 0;
        n_compared = 0;
        n_status   = 0;
        void'($urandom(29));
        apply_reset();
        for (int i = 0; i < 8; i++)
            wr_rx({i[1:0], i[1:0], i[2:0], i[1]});
        for (int b = 0; b < 8; b++) wr_cfg(3'(b), 1'b0);
        wr_cfg(3'b010, 1'b1);
        compare("clk off", 8'h00, 8'(clock_out));
        apply_reset();
        wr_cfg(3'b011, 1'b0);
        i_host.send(16'hC03E, 10);
        i_host.send(16'hC23E, 16);
        check_all();
        i_host.send(16'h0000, 16);
        compare("status", 8'h01, 8'(n_status));
        check_all();
        stop_test();
    end
endmodule
